// *** design/smsas_cfg.svh ***
/*
 * Constants for the servo mode switch and alarm sequencer.
 * Assumes a 200 MHz control clock; included by bare name.
 */
`ifndef SMSAS_CFG_SVH
`define SMSAS_CFG_SVH

// Change-mode setting codes.
`define SMSAS_CHG_POS_SPD  2'h1
`define SMSAS_CHG_SPD_TRQ  2'h2
`define SMSAS_CHG_TRQ_POS  2'h3

// Clock rate and timing.
`define SMSAS_CLK_MHZ      200
`define SMSAS_UV_ALARM_MS  15
`define SMSAS_UV_OFF_MS    20
`define SMSAS_CYC_PER_MS   (`SMSAS_CLK_MHZ * 1000)
`define SMSAS_UV_ALARM_CYC (`SMSAS_UV_ALARM_MS * `SMSAS_CYC_PER_MS)
`define SMSAS_UV_OFF_CYC   (`SMSAS_UV_OFF_MS * `SMSAS_CYC_PER_MS)

// Widths.
`define SMSAS_SPD_W        16
`define SMSAS_UV_CNT_W     23
`define SMSAS_DROOP_W      24

`endif

// *** design/smsas_pkg.sv ***
/*
 * Types for the servo mode switch and alarm sequencer.
 * Assumes smsas_cfg.svh for numeric constants.
 */
package smsas_pkg;

   typedef enum logic [2:0] {
      SMSAS_POS = 3'h1,
      SMSAS_SPD = 3'h2,
      SMSAS_TRQ = 3'h4
   } smsas_mode_type;

endpackage

// *** design/smsas_sync.sv ***
/*
 * Two-flop synchroniser for a group of contact inputs.
 * Assumes inputs are asynchronous to clk.
 */
`timescale 1ns/100ps
module smsas_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } smsas_sync_type;

   smsas_sync_type st_r;
   smsas_sync_type st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;

endmodule

// *** design/smsas_top.sv ***
/*
 * Control-mode arbitration and alarm sequencing for a servo drive.
 * Assumes contact inputs and supply monitor are asynchronous pins, speed
 * and fault inputs come from logic on clk, and rst_n follows control power.
 */
// Overview of operation
// - Position/speed mode: select low position, high speed.
// - Position/speed changes only at zero speed.
// - Position to speed clears droop count.
// - Toggle above zero speed stays ignored afterwards.
// - Toggle while qualifier off stays ignored.
// - Speed/torque mode: select low speed, high torque.
// - Speed/torque change applies immediately.
// - Start released at speed entry: decelerate to stop.
// - Torque/position: low torque, high position, zero speed.
// - Position to torque clears droop count.
// - Change mode from setting; absolute bars position modes.
// - Any alarm disables base drive at once.
// - Alarm clears on power cycle or reset rise.
// - Alarm reset refused while cause persists.
// - Undervoltage alarm after 15 ms interruption.
// - 20 ms shuts control; recovery clears, restarts.
// - Incremental system: alarm invalidates home position.
`timescale 1ns/100ps
`include "smsas_cfg.svh"
module smsas_top (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // Configuration
   input  wire logic [1:0]              change_mode_setting,
   input  wire logic                    absolute_system,
   input  wire logic [`SMSAS_SPD_W-1:0] zero_speed_threshold,
   // Contact inputs
   input  wire logic                    control_mode_select,
   input  wire logic                    servo_on_request,
   input  wire logic                    alarm_reset_input,
   input  wire logic                    reverse_start_select,
   input  wire logic                    forward_start_select,
   input  wire logic                    supply_ok,
   // Drive feedback
   input  wire logic [`SMSAS_SPD_W-1:0] speed_magnitude,
   input  wire logic                    overcurrent_cause,
   input  wire logic                    overload_first_cause,
   input  wire logic                    overload_second_cause,
   input  wire logic                    regeneration_cause,
   input  wire logic                    home_set,
   input  wire logic                    droop_pulse,
   // Status and control outputs
   output logic                         change_qualifier_output,
   output logic                         position_mode,
   output logic                         speed_mode,
   output logic                         torque_mode,
   output logic                         base_drive_enable,
   output logic                         decel_stop,
   output logic                         droop_clear,
   output logic [`SMSAS_DROOP_W-1:0]    droop_count,
   output logic                         alarm_active,
   output logic                         undervoltage_alarm,
   output logic                         overcurrent_alarm,
   output logic                         overload_first_alarm,
   output logic                         overload_second_alarm,
   output logic                         regeneration_alarm,
   output logic                         control_shutdown,
   output logic                         home_valid,
   output logic                         mode_config_error
);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisation.

   logic [5:0] pins_s;
   logic       sel_s;
   logic       son_s;
   logic       rst_s;
   logic       rev_s;
   logic       fwd_s;
   logic       sup_s;

   smsas_sync #(.W(6)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({control_mode_select, servo_on_request, alarm_reset_input,
               reverse_start_select, forward_start_select, supply_ok}),
      .q     (pins_s)
   );

   assign {sel_s, son_s, rst_s, rev_s, fwd_s, sup_s} = pins_s;

   ////////////////////////////////////////////////////////////////////////
   // Mode decode.

   // Maps the select level to a mode for the given change setting.
   function automatic smsas_pkg::smsas_mode_type sel_mode(
      input logic [1:0] cm,
      input logic       sel
   );
      smsas_pkg::smsas_mode_type m;
      m = smsas_pkg::SMSAS_SPD;
      if (cm == `SMSAS_CHG_POS_SPD) begin
         m = sel ? smsas_pkg::SMSAS_SPD : smsas_pkg::SMSAS_POS;
      end else if (cm == `SMSAS_CHG_SPD_TRQ) begin
         m = sel ? smsas_pkg::SMSAS_TRQ : smsas_pkg::SMSAS_SPD;
      end else if (cm == `SMSAS_CHG_TRQ_POS) begin
         m = sel ? smsas_pkg::SMSAS_POS : smsas_pkg::SMSAS_TRQ;
      end
      return m;
   endfunction

   logic cm_valid;
   logic zero_speed;
   logic needs_zero;
   logic any_cause;

   assign zero_speed = (speed_magnitude <= zero_speed_threshold);
   // Position-bearing modes are barred on absolute systems.
   assign cm_valid = !absolute_system ||
                     (change_mode_setting == `SMSAS_CHG_SPD_TRQ);
   assign needs_zero = (change_mode_setting != `SMSAS_CHG_SPD_TRQ);
   assign any_cause  = overcurrent_cause | overload_first_cause |
                       overload_second_cause | regeneration_cause;

   ////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      smsas_pkg::smsas_mode_type mode;
      logic                      sel_prev;
      logic                      blocked;
      logic                      rst_prev;
      logic                      uv;
      logic                      oc;
      logic                      ol1;
      logic                      ol2;
      logic                      rg;
      logic                      shut;
      logic [`SMSAS_UV_CNT_W-1:0] uv_cnt;
      logic                      home;
      logic                      clr;
      logic                      dec;
      logic [`SMSAS_DROOP_W-1:0] droop;
   } smsas_state_type;

   smsas_state_type st_r;
   smsas_state_type st_nxt;

   logic                      alarm_any;
   logic                      qual;
   smsas_pkg::smsas_mode_type want;
   logic                      reset_rise;

   assign alarm_any  = st_r.uv | st_r.oc | st_r.ol1 | st_r.ol2 | st_r.rg;
   assign want       = sel_mode(change_mode_setting, sel_s);
   assign qual       = cm_valid && !alarm_any &&
                       (!needs_zero || zero_speed);
   assign reset_rise = rst_s && !st_r.rst_prev;

   always_comb begin
      st_nxt          = st_r;
      st_nxt.sel_prev = sel_s;
      st_nxt.rst_prev = rst_s;
      st_nxt.clr      = 1'b0;
      st_nxt.dec      = 1'b0;

      // A select edge seen without the qualifier is never applied.
      if (sel_s != st_r.sel_prev) begin
         st_nxt.blocked = !qual;
      end
      if (!cm_valid) begin
         st_nxt.mode = smsas_pkg::SMSAS_SPD;
      end else if (want != st_r.mode && qual && !st_r.blocked &&
                   sel_s == st_r.sel_prev) begin
         st_nxt.mode = want;
         if (st_r.mode == smsas_pkg::SMSAS_POS) begin
            st_nxt.clr = 1'b1;
         end
         if (want == smsas_pkg::SMSAS_SPD && !(fwd_s ^ rev_s)) begin
            st_nxt.dec = 1'b1;
         end
      end

      // Droop accumulates only in position control.
      if (st_nxt.clr) begin
         st_nxt.droop = '0;
      end else if (st_r.mode == smsas_pkg::SMSAS_POS && droop_pulse) begin
         st_nxt.droop = st_r.droop + 1'b1;
      end

      // Undervoltage timer counts the interruption length.
      if (sup_s) begin
         st_nxt.uv_cnt = '0;
         st_nxt.shut   = 1'b0;
      end else if (st_r.uv_cnt != `SMSAS_UV_CNT_W'(`SMSAS_UV_OFF_CYC)) begin
         st_nxt.uv_cnt = st_r.uv_cnt + 1'b1;
      end
      if (!sup_s &&
          st_r.uv_cnt >= `SMSAS_UV_CNT_W'(`SMSAS_UV_ALARM_CYC - 1)) begin
         st_nxt.uv = 1'b1;
      end
      if (!sup_s &&
          st_r.uv_cnt >= `SMSAS_UV_CNT_W'(`SMSAS_UV_OFF_CYC - 1)) begin
         st_nxt.shut = 1'b1;
      end
      // Recovery from a shutdown clears the undervoltage alarm; other alarms stay latched.
      if (sup_s && st_r.shut) begin
         st_nxt.uv = 1'b0;
      end

      // Reset edge clears only alarms whose cause is gone; set wins.
      if (reset_rise) begin
         if (sup_s) st_nxt.uv = 1'b0;
         st_nxt.oc  = 1'b0;
         st_nxt.ol1 = 1'b0;
         st_nxt.ol2 = 1'b0;
         st_nxt.rg  = 1'b0;
      end
      if (overcurrent_cause) st_nxt.oc = 1'b1;
      if (overload_first_cause) st_nxt.ol1 = 1'b1;
      if (overload_second_cause) st_nxt.ol2 = 1'b1;
      if (regeneration_cause) st_nxt.rg = 1'b1;

      // Home is lost on any alarm in an incremental system.
      if (home_set) begin
         st_nxt.home = 1'b1;
      end
      if (!absolute_system && (alarm_any || any_cause)) begin
         st_nxt.home = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= '0;
         st_r.mode <= smsas_pkg::SMSAS_SPD;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign change_qualifier_output = qual;
   assign position_mode         = (st_r.mode == smsas_pkg::SMSAS_POS);
   assign speed_mode            = (st_r.mode == smsas_pkg::SMSAS_SPD);
   assign torque_mode           = (st_r.mode == smsas_pkg::SMSAS_TRQ);
   // Any active alarm gates base drive off, whatever servo-on does.
   assign base_drive_enable     = son_s && !alarm_active;
   assign decel_stop            = st_r.dec;
   assign droop_clear           = st_r.clr;
   assign droop_count           = st_r.droop;
   assign alarm_active          = alarm_any || any_cause;
   assign undervoltage_alarm    = st_r.uv;
   assign overcurrent_alarm     = st_r.oc;
   assign overload_first_alarm  = st_r.ol1;
   assign overload_second_alarm = st_r.ol2;
   assign regeneration_alarm    = st_r.rg;
   assign control_shutdown      = st_r.shut;
   assign home_valid            = st_r.home;
   assign mode_config_error     = !cm_valid;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   a_alarm_drive_off: assert property (@(posedge clk) disable iff (!rst_n)
      alarm_active |-> !base_drive_enable)
      else $error("base drive on during alarm");
   a_pos_spd_clear: assert property (@(posedge clk) disable iff (!rst_n)
      $past(position_mode) && speed_mode |-> droop_clear)
      else $error("droop not cleared on position exit");
   a_pos_trq_clear: assert property (@(posedge clk) disable iff (!rst_n)
      $past(position_mode) && torque_mode |-> droop_clear && droop_count == 0)
      else $error("droop not cleared to torque");
   a_zero_speed_gate: assert property (@(posedge clk) disable iff (!rst_n)
      cm_valid && needs_zero && !zero_speed |=> $stable(st_r.mode))
      else $error("mode changed above zero speed");
   a_blocked_hold: assert property (@(posedge clk) disable iff (!rst_n)
      st_r.blocked && sel_s == st_r.sel_prev && cm_valid |=> $stable(st_r.mode))
      else $error("ignored change was applied");
   a_qual_edge_block: assert property (@(posedge clk) disable iff (!rst_n)
      sel_s != st_r.sel_prev && !qual |=> st_r.blocked)
      else $error("toggle without qualifier not blocked");
   a_trq_immediate: assert property (@(posedge clk) disable iff (!rst_n)
      change_mode_setting == `SMSAS_CHG_SPD_TRQ && !alarm_any &&
      sel_s == st_r.sel_prev && !st_r.blocked && want != st_r.mode
      |=> st_r.mode == $past(want))
      else $error("speed/torque change delayed");
   a_uv_alarm_set: assert property (@(posedge clk) disable iff (!rst_n)
      !sup_s && st_r.uv_cnt == `SMSAS_UV_CNT_W'(`SMSAS_UV_ALARM_CYC - 1)
      |=> undervoltage_alarm)
      else $error("undervoltage not raised");
   a_reset_refused: assert property (@(posedge clk) disable iff (!rst_n)
      overcurrent_cause |=> overcurrent_alarm)
      else $error("alarm cleared with cause present");
   a_home_lost: assert property (@(posedge clk) disable iff (!rst_n)
      !absolute_system && alarm_active |=> !home_valid)
      else $error("home kept through alarm");
   a_abs_no_pos: assert property (@(posedge clk) disable iff (!rst_n)
      !cm_valid |=> speed_mode)
      else $error("position mode on absolute system");

   c_pos_to_spd: cover property (@(posedge clk) disable iff (!rst_n)
      $past(position_mode) && speed_mode);
   c_trq_entry: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(torque_mode));
   c_alarm_reset: cover property (@(posedge clk) disable iff (!rst_n)
      $fell(overcurrent_alarm));
   c_blocked: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(st_r.blocked));

endmodule

// *** tb/smsas_host.sv ***
/*
 * Host controller model that drives the contact pins of the sequencer.
 * Assumes bench commands change just after the clock's rising edge.
 */
`timescale 1ns/100ps
module smsas_host (
   // Clock and alarm report
   input  wire logic       clk,
   input  wire logic       alarm_active,
   // Bench commands
   input  wire logic       sel_cmd,
   input  wire logic       son_cmd,
   input  wire logic       res_cmd,
   input  wire logic [1:0] start_cmd,
   // Contact pins
   output logic            control_mode_select,
   output logic            servo_on_request,
   output logic            alarm_reset_input,
   output logic            reverse_start_select,
   output logic            forward_start_select
);
   logic dropped_r = 1'b0;

   // Servo-on stays off after an alarm until the bench withdraws it.
   always @(posedge clk) begin
      if (alarm_active === 1'b1)
         dropped_r <= 1'b1;
      else if (!son_cmd)
         dropped_r <= 1'b0;
   end
   assign servo_on_request = son_cmd & !dropped_r
                             & (alarm_active !== 1'b1);
   assign control_mode_select = sel_cmd;
   assign alarm_reset_input = res_cmd;
   assign forward_start_select = start_cmd[1];
   assign reverse_start_select = start_cmd[0];
endmodule

// *** tb/smsas_top_bench.sv ***
/*
 * Self-checking bench for the mode switch and alarm sequencer.
 * Assumes the host model drives the pins; supply stays good throughout.
 */
`timescale 1ns/100ps
`include "smsas_cfg.svh"
module smsas_top_bench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [1:0]  cm_set = 2'h0;
   logic        abs_set = 1'b0;
   logic [15:0] thr = 16'h0010;
   logic        sel_cmd = 1'b0;
   logic        son_cmd = 1'b0;
   logic        res_cmd = 1'b0;
   logic [1:0]  start_cmd = 2'h0;
   logic [15:0] speed = 16'h0000;
   logic [3:0]  cause = 4'h0;
   logic        home_set = 1'b0;
   logic        droop_pulse = 1'b0;
   logic        sel_p, son_p, res_p, rev_p, fwd_p, qual, pos_m, spd_m, trq_m;
   logic        base, dstop, dclr, alm_any, uv, sd, home_v, cfg_err;
   logic [3:0]  alm;
   logic [23:0] droop_count;
   logic [2:0]  prev_mode;
   int          errors = 0;
   int          checked = 0;
   int          clr_n = 0;
   int          dec_n = 0;
   int          n, c0, d0;
   smsas_pkg::smsas_mode_type exp_q[$];

   initial forever #2.5 clk = ~clk;

   smsas_host u_smsas_host (.clk(clk), .alarm_active(alm_any),
      .sel_cmd(sel_cmd), .son_cmd(son_cmd), .res_cmd(res_cmd),
      .start_cmd(start_cmd), .control_mode_select(sel_p),
      .servo_on_request(son_p), .alarm_reset_input(res_p),
      .reverse_start_select(rev_p), .forward_start_select(fwd_p));

   smsas_top u_smsas_top (.clk(clk), .rst_n(rst_n),
      .change_mode_setting(cm_set), .absolute_system(abs_set),
      .zero_speed_threshold(thr), .control_mode_select(sel_p),
      .servo_on_request(son_p), .alarm_reset_input(res_p),
      .reverse_start_select(rev_p), .forward_start_select(fwd_p),
      .supply_ok(1'b1), .speed_magnitude(speed),
      .overcurrent_cause(cause[0]), .overload_first_cause(cause[1]),
      .overload_second_cause(cause[2]), .regeneration_cause(cause[3]),
      .home_set(home_set), .droop_pulse(droop_pulse),
      .change_qualifier_output(qual), .position_mode(pos_m),
      .speed_mode(spd_m), .torque_mode(trq_m), .base_drive_enable(base),
      .decel_stop(dstop), .droop_clear(dclr), .droop_count(droop_count),
      .alarm_active(alm_any), .undervoltage_alarm(uv),
      .overcurrent_alarm(alm[0]), .overload_first_alarm(alm[1]),
      .overload_second_alarm(alm[2]), .regeneration_alarm(alm[3]),
      .control_shutdown(sd), .home_valid(home_v),
      .mode_config_error(cfg_err));

   ////////////////////////////////////////////////////////////////////////
   // Every mode change outside reset must match the oldest note; refusals leave none.
   always @(posedge clk) begin
      if (dclr === 1'b1) clr_n++;
      if (dstop === 1'b1) dec_n++;
      if (rst_n !== 1'b1)
         prev_mode <= {trq_m, spd_m, pos_m};
      else if ({trq_m, spd_m, pos_m} !== prev_mode) begin
         prev_mode <= {trq_m, spd_m, pos_m};
         checked++;
         if (exp_q.size() == 0) begin
            errors++;
            $display("ERROR at %0t: unexpected mode change", $time);
         end else if ({trq_m, spd_m, pos_m} !== exp_q.pop_front()) begin
            errors++;
            $display("ERROR at %0t: wrong mode", $time);
         end
      end
   end

   task automatic step(int k);
      repeat (k) @(posedge clk);
   endtask

   // Callers wait for the falling edge first, so that the arguments are
   // taken from settled outputs rather than from the launching edge.
   task automatic check(logic [23:0] got, logic [23:0] exp, string msg);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: %s", $time, msg);
      end
      @(posedge clk);
   endtask

   task automatic do_reset(logic [1:0] cm, logic ab, logic s);
      rst_n <= 1'b0;
      cm_set <= cm;
      abs_set <= ab;
      sel_cmd <= s;
      speed <= 16'h0000;
      step(12);
      rst_n <= 1'b1;
      step(8);
   endtask

   task automatic pulses();
      n = 1 + $urandom % 8;
      droop_pulse <= 1'b1;
      step(n);
      droop_pulse <= 1'b0;
      step(2);
   endtask

   task automatic end_test(string name);
      @(negedge clk);
      check(24'(exp_q.size()), 24'h0, "mode change missing");
      $display("test %s done", name);
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      step(20000);
      errors++;
      $display("ERROR at %0t: run timed out", $time);
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(46));
      exp_q.push_back(smsas_pkg::SMSAS_POS);
      do_reset(`SMSAS_CHG_POS_SPD, 1'b0, 1'b0);
      pulses();
      @(negedge clk);
      check(droop_count, 24'(n), "droop count");
      c0 = clr_n;
      exp_q.push_back(smsas_pkg::SMSAS_SPD);
      sel_cmd <= 1'b1;
      step(8);
      @(negedge clk);
      check(24'(clr_n - c0), 24'h1, "no droop clear");
      @(negedge clk);
      check(droop_count, 24'h0, "droop not cleared");
      speed <= thr;
      @(negedge clk);
      check(24'(qual), 24'h1, "qualifier at threshold");
      speed <= thr + 16'h0001 + 16'($urandom % 1000);
      @(negedge clk);
      check(24'(qual), 24'h0, "qualifier above zero speed");
      sel_cmd <= 1'b0;
      step(8);
      speed <= 16'h0000;
      step(8);
      sel_cmd <= 1'b1;
      step(8);
      exp_q.push_back(smsas_pkg::SMSAS_POS);
      sel_cmd <= 1'b0;
      step(8);
      end_test("pos_spd");

      do_reset(`SMSAS_CHG_SPD_TRQ, 1'b0, 1'b0);
      speed <= thr + 16'h0001 + 16'($urandom % 1000);
      exp_q.push_back(smsas_pkg::SMSAS_TRQ);
      sel_cmd <= 1'b1;
      step(8);
      d0 = dec_n;
      exp_q.push_back(smsas_pkg::SMSAS_SPD);
      sel_cmd <= 1'b0;
      step(8);
      @(negedge clk);
      check(24'(dec_n - d0), 24'h1, "no decel stop");
      end_test("spd_trq");

      exp_q.push_back(smsas_pkg::SMSAS_TRQ);
      do_reset(`SMSAS_CHG_TRQ_POS, 1'b0, 1'b0);
      exp_q.push_back(smsas_pkg::SMSAS_POS);
      sel_cmd <= 1'b1;
      step(8);
      pulses();
      c0 = clr_n;
      exp_q.push_back(smsas_pkg::SMSAS_TRQ);
      sel_cmd <= 1'b0;
      step(8);
      @(negedge clk);
      check(24'(clr_n - c0), 24'h1, "no droop clear");
      @(negedge clk);
      check(droop_count, 24'h0, "droop not cleared");
      end_test("trq_pos");

      do_reset(`SMSAS_CHG_POS_SPD, 1'b1, 1'b0);
      @(negedge clk);
      check(24'(cfg_err), 24'h1, "barred setting accepted");
      sel_cmd <= 1'b1;
      step(8);
      sel_cmd <= 1'b0;
      step(8);
      @(negedge clk);
      check(24'(spd_m), 24'h1, "barred mode entered");
      end_test("absolute");

      do_reset(`SMSAS_CHG_SPD_TRQ, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         son_cmd <= 1'b1;
         home_set <= 1'b1;
         step(1);
         home_set <= 1'b0;
         step(6);
         @(negedge clk);
         check(24'(base), 24'h1, "base drive off");
         cause[i] <= 1'b1;
         @(negedge clk);
         check(24'(base), 24'h0, "base drive on at alarm");
         @(negedge clk);
         check(24'(alm[i]), 24'h1, "alarm not latched");
         @(negedge clk);
         check(24'(home_v), 24'h0, "home kept");
         res_cmd <= 1'b1;
         step(4);
         res_cmd <= 1'b0;
         step(6);
         @(negedge clk);
         check(24'(alm[i]), 24'h1, "reset with cause");
         cause[i] <= 1'b0;
         step(2);
         res_cmd <= 1'b1;
         step(4);
         res_cmd <= 1'b0;
         step(6);
         @(negedge clk);
         check(24'({alm, alm_any}), 24'h0, "alarm not reset");
         @(negedge clk);
         check(24'(base), 24'h0, "restart while servo-on");
         son_cmd <= 1'b0;
         step(4);
      end
      cause[0] <= 1'b1;
      step(3);
      cause[0] <= 1'b0;
      do_reset(`SMSAS_CHG_SPD_TRQ, 1'b0, 1'b0);
      @(negedge clk);
      check(24'(alm), 24'h0, "alarm after power cycle");
      end_test("alarms");
      report_and_stop();
   end
endmodule
